// ==== src/fpec_pkg.sv ====
package fpec_pkg;
   // register index within a repeating group of four
   localparam logic [1:0]  REG_CTRL_IDX   = 2'h0;
   localparam logic [1:0]  REG_TEST_IDX   = 2'h1;
   localparam logic [1:0]  REG_TADDR_IDX  = 2'h2;
   localparam logic [1:0]  REG_TDATA_IDX  = 2'h3;
   // io port that switches access mode
   localparam logic [15:0] MODE_IO_PORT   = 16'hff0f;
   // control register field positions
   localparam int          GO_POS         = 0;
   localparam int          OP_LSB         = 1;
   localparam int          VER_LSB        = 3;
   localparam int          UNLOCK_LO_POS  = 5;
   localparam int          UNLOCK_HI_POS  = 6;
   localparam int          GUARD_LSB      = 8;
   localparam logic [15:0] CTRL_RESET     = 16'h0000;
   localparam logic [4:0]  TEST_RESET     = 5'h00;
   localparam logic [15:0] LATCH_RESET    = 16'h0000;
   localparam logic [15:0] ERASE_PATTERN  = 16'hffff;
   // operation codes
   typedef enum logic [1:0] {OP_NONE = 2'h0, OP_ERASE = 2'h1, OP_PROG = 2'h2, OP_RECOVER = 2'h3} fpec_op_e;
   // verify read modes
   typedef enum logic [1:0] {VR_NORMAL = 2'h0, VR_ONES = 2'h1, VR_ZEROS = 2'h2, VR_DEPLETE = 2'h3} fpec_ver_e;
   // host memory bus request
   typedef struct packed {
      logic        sel;
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } fpec_bus_s;
   // io instruction strobe
   typedef struct packed {
      logic        out_stb;
      logic        in_stb;
      logic [15:0] port;
   } fpec_io_s;
   // command to the array macro
   typedef struct packed {
      logic        active;
      fpec_op_e    op;
      fpec_ver_e   ver;
      logic [7:0]  guard;
      logic [15:0] addr;
      logic [15:0] data;
   } fpec_arr_s;
endpackage : fpec_pkg

// ==== src/fpec_ctrl.sv ====
`timescale 1ns/10ps
// Operation
// R1: verify field picks array read mode
// R2: operation field picks erase/program/recovery
// R3: go bit starts/stops, written with unlock
// R4: host clears go bit with unlock bits
// R5: go set locks latches, array ignored
// R6: array reads during go are undefined
// R7: five-bit test register exists
// R8: test register only in test mode
// R9: array-mode write captures address latch
// R10: register-mode write loads address latch
// R11: data latch from array or register write
// R12: host loads all ones before erase
// R13: erase refused unless data all ones
// R14: guard bits discouraged but present
// R15: io out/in switches register/array mode
// R16: unlock must be 1 0, reads zero
// R17: reset clears control register
// R18: four registers repeat every four words
// R19: undefined operation code modifies nothing
module fpec_ctrl
   import fpec_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire fpec_bus_s   bus,
   input  wire fpec_io_s    io,
   input  wire logic        test_mode,
   input  wire logic [15:0] array_rdata,
   output logic [15:0]      rdata,
   output logic             reg_mode,
   output fpec_arr_s        arr,
   output logic             arr_rd
);

   logic [15:0] ctrl_r;      // control register, unlock bits never stored
   logic [4:0]  test_r;      // test-only register
   logic [15:0] taddr_r;     // program target address latch
   logic [15:0] tdata_r;     // program value latch
   logic        reg_mode_r;  // 1 = registers replace array
   logic [15:0] rdata_r;     // registered read data
   logic        go;          // current go bit
   logic        reg_wr;      // register write strobe
   logic        arr_wr;      // array write strobe
   logic [15:0] ctrl_nxt;    // next control value
   fpec_op_e    op_sel;      // selected operation

   // register index from the low two address bits, aliases across range
   function automatic logic [1:0] reg_index(input logic [15:0] a);
      return a[1:0]; // [R18]
   endfunction : reg_index

   // unlock pattern 1 0 in a written control word, shared by logic and checks
   function automatic logic unlock_ok(input logic [15:0] d);
      return d[UNLOCK_HI_POS] && !d[UNLOCK_LO_POS]; // [R16]
   endfunction : unlock_ok

   assign go      = ctrl_r[GO_POS];
   assign op_sel  = fpec_op_e'(ctrl_r[OP_LSB +: 2]);
   assign reg_wr  = bus.sel && bus.wr && reg_mode_r;
   assign arr_wr  = bus.sel && bus.wr && !reg_mode_r && !go; // [R5]

   // access mode switch on io instructions
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_mode_r <= 1'b0;
      end
      else if (io.out_stb && io.port == MODE_IO_PORT)
      begin
         reg_mode_r <= 1'b1; // [R15]
      end
      else if (io.in_stb && io.port == MODE_IO_PORT)
      begin
         reg_mode_r <= 1'b0; // [R15]
      end
   end

   // next control value; go only honoured with unlock 1 0
   always_comb
   begin
      ctrl_nxt = ctrl_r;
      if (unlock_ok(bus.wdata)) // [R16]
      begin
         ctrl_nxt[GO_POS] = bus.wdata[GO_POS]; // [R3] [R4]
         // erase refused when the value latch is not all ones
         if (bus.wdata[GO_POS] && fpec_op_e'(bus.wdata[OP_LSB +: 2]) == OP_ERASE
             && tdata_r != ERASE_PATTERN)
         begin
            ctrl_nxt[GO_POS] = 1'b0; // [R13]
         end
      end
      else
      begin
         ctrl_nxt[GO_POS] = ctrl_r[GO_POS];
      end
      // other fields frozen while go is set, so guards cannot slip
      if (!go)
      begin
         ctrl_nxt[OP_LSB +: 2]   = bus.wdata[OP_LSB +: 2];     // [R2]
         ctrl_nxt[VER_LSB +: 2]  = bus.wdata[VER_LSB +: 2];    // [R1]
         ctrl_nxt[GUARD_LSB +: 8] = bus.wdata[GUARD_LSB +: 8]; // [R14]
      end
      ctrl_nxt[UNLOCK_LO_POS] = 1'b0; // [R16]
      ctrl_nxt[UNLOCK_HI_POS] = 1'b0; // [R16]
      // reserved bit 7 always reads back zero
      ctrl_nxt[7]             = 1'b0;
   end

   // control register
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_r <= CTRL_RESET; // [R17]
      end
      else if (reg_wr && reg_index(bus.addr) == REG_CTRL_IDX)
      begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // test register, dead outside test mode
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         test_r <= TEST_RESET;
      end
      else if (reg_wr && test_mode && reg_index(bus.addr) == REG_TEST_IDX)
      begin
         test_r <= bus.wdata[4:0]; // [R7] [R8]
      end
   end

   // target address latch
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         taddr_r <= LATCH_RESET;
      end
      else if (!go) // [R5]
      begin
         if (arr_wr)
         begin
            taddr_r <= bus.addr; // [R9]
         end
         else if (reg_wr && reg_index(bus.addr) == REG_TADDR_IDX)
         begin
            taddr_r <= bus.wdata; // [R10]
         end
      end
   end

   // value latch
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tdata_r <= LATCH_RESET;
      end
      else if (!go) // [R5]
      begin
         if (arr_wr || (reg_wr && reg_index(bus.addr) == REG_TDATA_IDX))
         begin
            tdata_r <= bus.wdata; // [R11]
         end
      end
   end

   // read path; array data while go is set is not meaningful
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_r <= 16'h0000;
      end
      else if (bus.sel && bus.rd)
      begin
         if (!reg_mode_r)
         begin
            rdata_r <= go ? 16'h0000 : array_rdata; // [R6]
         end
         else
         begin
            unique case (reg_index(bus.addr))
               REG_CTRL_IDX:  rdata_r <= ctrl_r;
               REG_TEST_IDX:  rdata_r <= test_mode ? {11'h000, test_r} : 16'h0000; // [R8]
               REG_TADDR_IDX: rdata_r <= taddr_r;
               REG_TDATA_IDX: rdata_r <= tdata_r;
            endcase
         end
      end
   end

   // outputs to host and array macro
   assign rdata      = rdata_r;
   assign reg_mode   = reg_mode_r;
   assign arr_rd     = bus.sel && bus.rd && !reg_mode_r && !go; // [R5]
   // whole command word in one assignment, so the struct has a single driver
   assign arr        = '{active: go && op_sel != OP_NONE, // [R19]
                         op:     op_sel,
                         ver:    fpec_ver_e'(ctrl_r[VER_LSB +: 2]),
                         guard:  ctrl_r[GUARD_LSB +: 8],
                         addr:   taddr_r,
                         data:   tdata_r};

   // assertions
   // a keyed control write: register mode, control index, unlock 1 0
   sequence s_keyed_write;
      reg_wr && reg_index(bus.addr) == REG_CTRL_IDX && unlock_ok(bus.wdata);
   endsequence
   // any control write, keyed or not
   sequence s_ctrl_write;
      reg_wr && reg_index(bus.addr) == REG_CTRL_IDX;
   endsequence

   // no disable here: this one looks at the reset release itself
   AST_RESET_CLEAR: assert property (@(posedge mclk) $rose(rst_n) |-> ctrl_r == CTRL_RESET) // [R17]
      else $error("control not clear after reset");
   // unlock bits are never stored
   AST_UNLOCK_ZERO: assert property (@(posedge mclk) disable iff (!rst_n) // [R16]
      ctrl_r[UNLOCK_HI_POS:UNLOCK_LO_POS] == 2'h0)
      else $error("unlock bits stored");

   // go only moves on a keyed control write
   AST_GO_KEY: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
      s_ctrl_write ##0 !unlock_ok(bus.wdata) |=> $stable(go))
      else $error("go changed without unlock");
   // keyed go starts unless an erase meets a dirty value latch
   AST_GO_START: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
      s_keyed_write ##0 (bus.wdata[GO_POS] && (bus.wdata[OP_LSB +: 2] != OP_ERASE || tdata_r == ERASE_PATTERN))
      |=> go)
      else $error("keyed go did not start");
   // keyed write with go clear stops the operation
   AST_GO_STOP: assert property (@(posedge mclk) disable iff (!rst_n) // [R3]
      s_keyed_write ##0 !bus.wdata[GO_POS] |=> !go)
      else $error("keyed stop did not clear go");
   // erase never starts on a value latch other than all ones
   AST_ERASE_GUARD: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
      $rose(go) |-> (op_sel != OP_ERASE || tdata_r == ERASE_PATTERN))
      else $error("erase started without all ones");

   // latches hold while go stays set
   AST_LATCH_LOCK: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
      go && $past(go) |-> $stable(taddr_r) && $stable(tdata_r))
      else $error("latch moved while go set");
   // operation, verify and guard fields frozen while go is set
   AST_FIELD_FREEZE: assert property (@(posedge mclk) disable iff (!rst_n) // [R5]
      go ##0 s_ctrl_write |=> $stable(op_sel) && $stable(arr.ver) && $stable(arr.guard))
      else $error("control field moved while go set");
   // array reads during go give the fixed filler word
   AST_READ_LOCK: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
      go && bus.sel && bus.rd && !reg_mode_r |=> rdata_r == 16'h0000)
      else $error("array read not blanked while go set");
   // array-mode write captures the bus address
   AST_ADDR_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
      arr_wr |=> taddr_r == $past(bus.addr))
      else $error("address not captured");
   // register-mode write loads the address latch directly
   AST_ADDR_REG: assert property (@(posedge mclk) disable iff (!rst_n) // [R10]
      reg_wr && !go && reg_index(bus.addr) == REG_TADDR_IDX |=> taddr_r == $past(bus.wdata))
      else $error("address latch not loaded by register write");
   // array-mode write captures the written value
   AST_DATA_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
      arr_wr |=> tdata_r == $past(bus.wdata))
      else $error("value not captured");

   // out instruction enters register mode
   AST_MODE_SWITCH: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
      io.out_stb && io.port == MODE_IO_PORT |=> reg_mode_r)
      else $error("mode not switched");
   // in instruction returns to array mode
   AST_MODE_RETURN: assert property (@(posedge mclk) disable iff (!rst_n) // [R15]
      io.in_stb && !io.out_stb && io.port == MODE_IO_PORT |=> !reg_mode_r)
      else $error("mode not returned");
   // control register readable at every aliased index 0
   AST_ALIAS_READ: assert property (@(posedge mclk) disable iff (!rst_n) // [R18]
      reg_mode_r && bus.sel && bus.rd && reg_index(bus.addr) == REG_CTRL_IDX |=> rdata_r == $past(ctrl_r))
      else $error("control read wrong");
   // keyed go with the undefined code leaves the array idle
   AST_NO_OP: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
      s_keyed_write ##0 (bus.wdata[GO_POS] && bus.wdata[OP_LSB +: 2] == OP_NONE && !go) |=> !arr.active)
      else $error("undefined op active");
   // test register frozen outside test mode
   AST_TEST_HIDE: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
      !test_mode |=> $stable(test_r))
      else $error("test register written outside test mode");
   // test register reads zero outside test mode
   AST_TEST_READ: assert property (@(posedge mclk) disable iff (!rst_n) // [R8]
      reg_mode_r && bus.sel && bus.rd && !test_mode && reg_index(bus.addr) == REG_TEST_IDX |=> rdata_r == 16'h0000)
      else $error("test register visible outside test mode");
   // verify field follows an unlocked control write
   AST_VERIFY_FIELD: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
      !go ##0 s_ctrl_write |=> arr.ver == $past(bus.wdata[VER_LSB +: 2]))
      else $error("verify field not taken");
   // operation field follows an unlocked control write
   AST_OP_FIELD: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
      !go ##0 s_ctrl_write |=> arr.op == $past(bus.wdata[OP_LSB +: 2]))
      else $error("operation field not taken");

endmodule : fpec_ctrl

// ==== sim/fpec_array_model.sv ====
`timescale 1ns/10ps
// behavioural array macro: returns a fixed word while read-enabled
module fpec_array_model
#(
   parameter logic [15:0] ARR_WORD = 16'h3c5a  // stored word seen by every read
)
(
   input  wire logic        mclk,
   input  wire logic        arr_rd,
   output logic [15:0]      array_rdata
);
   logic flip_r = 1'b0;  // pattern phase for idle output
   // idle phase flips each cycle
   always_ff @(posedge mclk)
   begin
      flip_r <= ~flip_r;
   end
   // outside reads the bus shows a moving pattern, never stale data
   assign array_rdata = arr_rd ? ARR_WORD : (flip_r ? 16'h5a5a : 16'ha5a5);
endmodule : fpec_array_model

// ==== sim/test_flash_program_erase_control.sv ====
`timescale 1ns/10ps
module test_flash_program_erase_control;
   import fpec_pkg::*;
   localparam logic [15:0] ARR_WORD = 16'h3c5a;  // word held by the array model
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic        test_mode = 1'b0;
   fpec_bus_s   bus = '0;
   fpec_io_s    io = '0;
   logic [15:0] array_rdata;
   logic [15:0] rdata;
   logic [15:0] rv;
   logic        rd_en_seen;  // array read enable seen inside the last read strobe
   logic        reg_mode;
   logic        arr_rd;
   fpec_arr_s   arr;
   int          num_errors = 0;
   int          compares = 0;
   fpec_ctrl dut (.mclk(mclk), .rst_n(rst_n), .bus(bus), .io(io), .test_mode(test_mode),
      .array_rdata(array_rdata), .rdata(rdata), .reg_mode(reg_mode), .arr(arr), .arr_rd(arr_rd));
   fpec_array_model #(.ARR_WORD(ARR_WORD)) arr_mdl (.mclk(mclk), .arr_rd(arr_rd), .array_rdata(array_rdata));
   // 100 MHz core clock
   always #5 mclk = ~mclk;
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // one-cycle write strobe, then a settle cycle
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge mclk) bus = '{sel: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge mclk) bus = '0;
      @(negedge mclk);
   endtask : wr
   task automatic rd(input logic [15:0] a, output logic [15:0] v);
      @(negedge mclk) bus = '{sel: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      #1 rd_en_seen = arr_rd;
      @(negedge mclk) bus = '0;
      @(negedge mclk) v = rdata;
   endtask : rd
   // out (1) or in (0) instruction on the mode port
   task automatic iox(input logic o);
      @(negedge mclk) io = '{out_stb: o, in_stb: ~o, port: MODE_IO_PORT};
      @(negedge mclk) io = '0;
      @(negedge mclk);
   endtask : iox
   task automatic t_array();
      chk("reset_active", {15'h0, arr.active}, 16'h0000);
      chk("reset_mode", {15'h0, reg_mode}, 16'h0000);
      wr(16'h1234, 16'habcd);
      chk("latch_addr", arr.addr, 16'h1234);
      chk("latch_data", arr.data, 16'habcd);
      rd(16'h0020, rv);
      chk("array_read", rv, ARR_WORD);
      chk("arr_rd_open", {15'h0, rd_en_seen}, 16'h0001);
      iox(1'b1);
      chk("reg_mode", {15'h0, reg_mode}, 16'h0001);
      rd(16'h0004, rv);
      chk("ctrl_reset", rv, CTRL_RESET);
      chk("arr_rd_regmode", {15'h0, rd_en_seen}, 16'h0000);
      wr(16'h0006, 16'h2468);
      chk("alias_addr", arr.addr, 16'h2468);
      rd(16'h000a, rv);
      chk("alias_read", rv, 16'h2468);
      $display("test array done");
   endtask : t_array
   task automatic t_test_reg();
      wr({14'h0, REG_TEST_IDX}, 16'h0015);
      rd({14'h0, REG_TEST_IDX}, rv);
      chk("test_locked", rv, 16'h0000);
      test_mode = 1'b1;
      wr({14'h0, REG_TEST_IDX}, 16'h0015);
      rd({14'h0, REG_TEST_IDX}, rv);
      chk("test_open", rv, 16'h0015);
      test_mode = 1'b0;
      $display("test test_reg done");
   endtask : t_test_reg
   task automatic t_exec();
      wr({14'h0, REG_TDATA_IDX}, ERASE_PATTERN);
      wr(16'h0000, 16'h0003);
      chk("no_unlock", {15'h0, arr.active}, 16'h0000);
      // every op and verify code with go and unlock set
      for (int i = 0; i < 4; i++)
      begin
         wr(16'h0000, 16'h0041 | (16'(i) << 1) | (16'(i) << 3));
         chk("go_active", {15'h0, arr.active}, {15'h0, i != 0});
         chk("op_code", {14'h0, arr.op}, 16'(i));
         chk("ver_code", {14'h0, arr.ver}, 16'(i));
         chk("guard_clear", {8'h0, arr.guard}, 16'h0000);
         rd(16'h0000, rv);
         chk("unlock_rd", rv & 16'h0060, 16'h0000);
         if (i != 3)
            wr(16'h0000, 16'h0040);
      end
      iox(1'b0);
      wr(16'h0100, 16'h1111);
      chk("locked_addr", arr.addr, 16'h2468);
      rd(16'h0100, rv);
      chk("locked_read", rv, 16'h0000);
      chk("arr_rd_locked", {15'h0, rd_en_seen}, 16'h0000);
      iox(1'b1);
      wr(16'h0000, 16'h0002);
      chk("stop_no_key", {15'h0, arr.active}, 16'h0001);
      chk("op_frozen", {14'h0, arr.op}, 16'h0003);
      wr(16'h0000, 16'h0040);
      chk("stop", {15'h0, arr.active}, 16'h0000);
      wr({14'h0, REG_TDATA_IDX}, 16'h1234);
      wr(16'h0000, 16'h0043);
      chk("erase_refused", {15'h0, arr.active}, 16'h0000);
      $display("test exec done");
   endtask : t_exec
   // reset in mid-run while a program operation is going
   task automatic t_reset();
      wr(16'h0000, 16'h0045);
      chk("prog_go", {15'h0, arr.active}, 16'h0001);
      rd({14'h0, REG_TADDR_IDX}, rv);
      chk("go_taddr", rv, 16'h2468);
      @(negedge mclk) rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      chk("rst_active", {15'h0, arr.active}, 16'h0000);
      chk("rst_mode", {15'h0, reg_mode}, 16'h0000);
      chk("rst_rdata", rdata, 16'h0000);
      iox(1'b1);
      rd(16'h0000, rv);
      chk("rst_ctrl", rv, CTRL_RESET);
      $display("test reset done");
   endtask : t_reset
   task automatic complete_run();
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // watchdog: the whole sequence needs well under 1000 cycles
   initial
   begin
      #20000;
      num_errors++;
      complete_run();
   end
   initial
   begin
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      t_array();
      t_test_reg();
      t_exec();
      t_reset();
      complete_run();
   end
endmodule : test_flash_program_erase_control
